// [core/svga_seq_memory_mode_ctrl.sv]
// sequencer memory mode and extension control registers with plane mapping
`timescale 1ns/1ps
`default_nettype none
`include "svga_seq_params.svh"
module svga_seq_memory_mode_ctrl
  import svga_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // host i/o port
  input wire logic [15:0] io_addr,
  input wire logic io_wr_stb,
  input wire logic io_rd_stb,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_r,
  output logic io_rd_ack_r,
  output logic io_rd_hit_r,
  // lock state of the extension register, from the unlock logic
  input wire logic ext_unlocked,
  // neighbouring sequencer and graphics controller registers
  input wire logic [7:0] seq_clocking_mode_reg,
  input wire logic [3:0] plane_write_mask,
  input wire logic [1:0] read_plane_select,
  input wire logic [7:0] start_addr_lo,
  input wire logic [7:0] start_addr_hi,
  // host memory access
  input wire logic host_mem_stb,
  input wire logic [17:0] host_addr,
  output logic [3:0] plane_write_en,
  output logic [1:0] read_plane,
  output logic [16:0] memory_address_out,
  output logic mem_access_valid,
  // font serializer feed
  input wire logic [7:0] font_byte,
  output logic [7:0] font_byte_ordered_r,
  // display controls
  output logic extended_memory_flag_r,
  output logic odd_even_mode_r,
  output logic [3:0] char_width_r,
  output logic [16:0] serial_start_addr_r,
  output logic interlace_en_r,
  output logic last_pixel_vga_rule_r,
  output logic dual_frame_en_r,
  output logic hde_counts_pixels_r
);

  // register state
  reg8_t seq_index_r; // sequencer index held at the index port
  reg8_t memory_mode_r; // only writable bits are ever set
  reg8_t extended_control_zero_r; // extension control register

  // port and index decode
  wire idx_port = (io_addr == `SEQ_INDEX_PORT);
  wire data_port = (io_addr == `SEQ_DATA_PORT);
  wire sel_mm = data_port && (seq_index_r == `IDX_MEM_MODE);
  wire sel_ec = data_port && (seq_index_r == `IDX_EXT_CTRL0);
  // writes that land in a register
  wire wr_index = io_wr_stb && idx_port;
  wire wr_mm = io_wr_stb && sel_mm;
  wire wr_ec = io_wr_stb && sel_ec && ext_unlocked;

  // next register values
  wire [7:0] mm_nxt = io_wdata & `MEM_MODE_RW_MASK;
  wire [7:0] seq_index_nxt = io_wdata;

  // read selection: locked extension reads give zero
  wire [7:0] rd_sel =
    idx_port ? seq_index_r :
    sel_mm ? memory_mode_r :
    sel_ec ? (ext_unlocked ? extended_control_zero_r : 8'h00) :
    8'h00;
  // this block answers for the index port and its two indices
  wire rd_hit = idx_port || sel_mm || sel_ec;

  // fields of the two registers
  wire chain4 = memory_mode_r[`MM_CHAIN4_BIT];
  wire seq_addr = memory_mode_r[`MM_SEQ_ADDR_BIT];
  wire [1:0] width_hi = extended_control_zero_r[`EC_WIDTH_LSB +: 2];
  wire cpu_div2 = extended_control_zero_r[`EC_DIV2_BIT];
  wire odd_font = extended_control_zero_r[`EC_ODD_FONT_BIT];
  wire lsb_first = extended_control_zero_r[`EC_ORDER_BIT];

  // width: base plus twice the high field, one more when clock bit 0 is low
  wire [3:0] width_twice = {1'b0, width_hi, 1'b0};
  wire [3:0] width_extra = {3'h0, ~seq_clocking_mode_reg[0]};
  wire [3:0] char_width_nxt = `CHAR_WIDTH_BASE + width_twice + width_extra;

  // addressing scheme, chain-four first, then divide-by-2, then odd/even
  wire addr_mode_e mode_sel =
    chain4 ? ADDR_CHAIN4 :
    cpu_div2 ? ADDR_DIV2 :
    !seq_addr ? ADDR_ODD_EVEN :
    ADDR_SEQUENTIAL;

  // font byte mirrored when bit 0 is to be shown first
  wire [7:0] font_mirror;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mirror
      assign font_mirror[gi] = font_byte[7 - gi];
    end
  endgenerate
  wire [7:0] font_nxt = lsb_first ? font_mirror : font_byte;

  // plane mapper link
  plane_sel_if psel ();
  assign psel.mode = mode_sel;
  assign psel.plane_write_mask = plane_write_mask;
  assign psel.read_plane_select = read_plane_select;
  assign psel.host_addr = host_addr;
  assign psel.host_mem_stb = host_mem_stb;

  // mapper registers its results, so these outputs come from flip-flops
  plane_mapper u_mapper (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(psel.mapper)
  );
  assign plane_write_en = psel.write_en;
  assign read_plane = psel.read_plane;
  assign memory_address_out = psel.mem_addr;
  assign mem_access_valid = psel.mem_valid;

  // sequencer index
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_index_r <= `SEQ_INDEX_RST;
    end else if (wr_index) begin
      seq_index_r <= seq_index_nxt;
    end
  end

  // memory mode register, reserved bits never stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_mode_r <= `MEM_MODE_RST;
    end else if (wr_mm) begin
      memory_mode_r <= mm_nxt;
    end
  end

  // extension control register, written only while unlocked
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extended_control_zero_r <= `EXT_CTRL0_RST;
    end else if (wr_ec) begin
      extended_control_zero_r <= io_wdata;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_r <= 8'h00;
      io_rd_ack_r <= 1'b0;
      io_rd_hit_r <= 1'b0;
    end else begin
      io_rd_ack_r <= io_rd_stb;
      io_rd_hit_r <= io_rd_stb && rd_hit;
      if (io_rd_stb) begin
        io_rdata_r <= rd_sel;
      end
    end
  end

  // memory mode controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extended_memory_flag_r <= 1'b0;
      odd_even_mode_r <= 1'b0;
    end else begin
      extended_memory_flag_r <= memory_mode_r[`MM_EXT_MEM_BIT];
      odd_even_mode_r <= !seq_addr && !chain4;
    end
  end

  // character width and last pixel source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      char_width_r <= `CHAR_WIDTH_BASE;
      last_pixel_vga_rule_r <= 1'b0;
    end else begin
      char_width_r <= char_width_nxt;
      last_pixel_vga_rule_r <= char_width_nxt[0] && !odd_font;
    end
  end

  // start address, interlace and dual buffer controls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_start_addr_r <= 17'h00000;
      interlace_en_r <= 1'b0;
      dual_frame_en_r <= 1'b0;
      hde_counts_pixels_r <= 1'b0;
    end else begin
      serial_start_addr_r <= {extended_control_zero_r[`EC_START16_BIT],
                              start_addr_hi, start_addr_lo};
      interlace_en_r <= extended_control_zero_r[`EC_INTERLACE_BIT];
      dual_frame_en_r <= extended_control_zero_r[`EC_DUAL_BIT];
      hde_counts_pixels_r <= extended_control_zero_r[`EC_DUAL_BIT];
    end
  end

  // font byte in display order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      font_byte_ordered_r <= 8'h00;
    end else begin
      font_byte_ordered_r <= font_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // locked writes leave the extension register alone
  property p_locked_write;
    io_wr_stb && sel_ec && !ext_unlocked |=>
      extended_control_zero_r == $past(extended_control_zero_r);
  endproperty
  a_p_locked_write: assert property (p_locked_write) else $error("locked write landed");

  // locked reads return zero with a hit
  property p_locked_read;
    io_rd_stb && sel_ec && !ext_unlocked |=> io_rdata_r == 8'h00 && io_rd_hit_r;
  endproperty
  a_p_locked_read: assert property (p_locked_read) else $error("locked read leaked");

  // unlocked write lands in the extension register one cycle later
  property p_ext_write;
    io_wr_stb && sel_ec && ext_unlocked |=> extended_control_zero_r == $past(io_wdata);
  endproperty
  a_p_ext_write: assert property (p_ext_write) else $error("extension write lost");

  // memory mode read shows reserved bits as zero
  property p_mm_reserved;
    io_rd_stb && sel_mm |=> io_rd_ack_r && (io_rdata_r & ~`MEM_MODE_RW_MASK) == 8'h00;
  endproperty
  a_p_mm_reserved: assert property (p_mm_reserved) else $error("reserved bits set");

  // width follows the fields one cycle on when they hold still
  property p_char_width;
    $stable(extended_control_zero_r) && $stable(seq_clocking_mode_reg[0]) ##1
      $stable(extended_control_zero_r) |->
      char_width_r == `CHAR_WIDTH_BASE + {1'b0, width_hi, 1'b0}
                      + {3'h0, ~seq_clocking_mode_reg[0]} || $changed(seq_clocking_mode_reg[0]);
  endproperty
  a_p_char_width: assert property (p_char_width) else $error("character width wrong");

  // width always within its legal range
  property p_width_range;
    char_width_r >= `CHAR_WIDTH_BASE && char_width_r <= `CHAR_WIDTH_MAX;
  endproperty
  a_p_width_range: assert property (p_width_range) else $error("width out of range");

  // start address bit 16 tracks the extension bit
  property p_start16;
    1'b1 |=> serial_start_addr_r[16] == $past(extended_control_zero_r[`EC_START16_BIT])
             && serial_start_addr_r[15:0] == $past({start_addr_hi, start_addr_lo});
  endproperty
  a_p_start16: assert property (p_start16) else $error("start address wrong");

  // bit order: first displayed bit is bit 7 or bit 0
  property p_order;
    1'b1 |=> font_byte_ordered_r[7] == ($past(lsb_first) ? $past(font_byte[0])
                                                          : $past(font_byte[7]));
  endproperty
  a_p_order: assert property (p_order) else $error("pixel order wrong");

  c_unlocked_write: cover property (io_wr_stb && sel_ec && ext_unlocked);
  c_locked_read: cover property (io_rd_stb && sel_ec && !ext_unlocked);
  c_interlace: cover property (interlace_en_r && dual_frame_en_r);

endmodule : svga_seq_memory_mode_ctrl
`default_nettype wire

// [core/svga_seq_params.svh]
// constants for the sequencer memory mode and extension control registers
//
// Contract
// - chain-four clear: mask and read select pick plane; the code also uses address bit 0 in odd/even and divide-by-2
// - chain-four set: address bits 1..0 pick map
// - bit 2 low odd/even, high sequential addressing
// - bit 1 flags extended memory above 64 KB
// - memory mode bits 0 and 7..4 reserved
// - extension register blocked for access while locked
// - character width 6 + 2*high + clock bit; the code adds one when clock bit 0 is low
// - bit 2 is start address bit 16
// - bit 3 forces interlaced scanning
// - divide-by-2 shifts host address down one
// - bit 5 makes odd last pixel font data
// - bit 6 selects font bit display order
// - bit 7 fetches second graphics frame buffer
// - bit 7 changes display end to pixel count
// - extension register at 03c5 index 05, resets 01
// - write mask bits enable writes per plane
`ifndef SVGA_SEQ_PARAMS_SVH
`define SVGA_SEQ_PARAMS_SVH

`define SEQ_INDEX_PORT 16'h03c4
`define SEQ_DATA_PORT 16'h03c5
`define IDX_MEM_MODE 8'h04
`define IDX_EXT_CTRL0 8'h05
`define SEQ_INDEX_RST 8'h00
`define MEM_MODE_RST 8'h00
`define EXT_CTRL0_RST 8'h01
`define MEM_MODE_RW_MASK 8'h0e
`define MM_EXT_MEM_BIT 1
`define MM_SEQ_ADDR_BIT 2
`define MM_CHAIN4_BIT 3
`define EC_WIDTH_LSB 0
`define EC_START16_BIT 2
`define EC_INTERLACE_BIT 3
`define EC_DIV2_BIT 4
`define EC_ODD_FONT_BIT 5
`define EC_ORDER_BIT 6
`define EC_DUAL_BIT 7
`define CHAR_WIDTH_BASE 4'h6
`define CHAR_WIDTH_MAX 4'hd

`endif

// [core/svga_seq_pkg.sv]
// types shared by the sequencer memory mode block and its plane mapper
package svga_seq_pkg;

  // host addressing scheme chosen from the two registers
  typedef enum logic [1:0] {
    ADDR_SEQUENTIAL,
    ADDR_ODD_EVEN,
    ADDR_CHAIN4,
    ADDR_DIV2
  } addr_mode_e;

  // eight bit register value
  typedef logic [7:0] reg8_t;

endpackage : svga_seq_pkg

// [core/plane_sel_if.sv]
// carrier between the register block and the plane mapper
`timescale 1ns/1ps
`default_nettype none
interface plane_sel_if;
  import svga_seq_pkg::*;
  addr_mode_e mode; // active addressing scheme
  logic [3:0] plane_write_mask; // per plane write enables from software
  logic [1:0] read_plane_select; // plane for reads in plain mode
  logic [17:0] host_addr; // host memory address
  logic host_mem_stb; // host memory access strobe
  logic [3:0] write_en; // planes written by this access
  logic [1:0] read_plane; // plane read by this access
  logic [16:0] mem_addr; // display memory address
  logic mem_valid; // mapped access ready

  // register side drives the controls and takes the results
  modport ctrl (
    output mode, plane_write_mask, read_plane_select, host_addr, host_mem_stb,
    input write_en, read_plane, mem_addr, mem_valid
  );
  // mapper side takes the controls and drives the results
  modport mapper (
    input mode, plane_write_mask, read_plane_select, host_addr, host_mem_stb,
    output write_en, read_plane, mem_addr, mem_valid
  );
endinterface : plane_sel_if
`default_nettype wire

// [core/plane_mapper.sv]
// maps a host memory access onto display planes and a memory address
`timescale 1ns/1ps
`default_nettype none
module plane_mapper
  import svga_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  plane_sel_if.mapper bus
);

  // one-hot map selected by the two low address bits
  wire [3:0] chain_onehot = 4'h1 << bus.host_addr[1:0];
  // even maps for address bit 0 low, odd maps for high
  wire [3:0] oe_maps = bus.host_addr[0] ? 4'ha : 4'h5;
  // maps 0/1 or maps 2/3 under divide-by-2
  wire [3:0] div_maps = bus.host_addr[0] ? 4'hc : 4'h3;

  // write enables per scheme, always gated by the mask
  wire [3:0] we_nxt =
    (bus.mode == ADDR_CHAIN4) ? (chain_onehot & bus.plane_write_mask) :
    (bus.mode == ADDR_DIV2) ? (div_maps & bus.plane_write_mask) :
    (bus.mode == ADDR_ODD_EVEN) ? (oe_maps & bus.plane_write_mask) :
    bus.plane_write_mask;
  // read plane per scheme
  wire [1:0] rp_nxt =
    (bus.mode == ADDR_CHAIN4) ? bus.host_addr[1:0] :
    (bus.mode == ADDR_DIV2) ? {bus.host_addr[0], bus.read_plane_select[0]} :
    (bus.mode == ADDR_ODD_EVEN) ? {bus.read_plane_select[1], bus.host_addr[0]} :
    bus.read_plane_select;
  // memory address per scheme
  wire [16:0] mem_addr_nxt =
    (bus.mode == ADDR_CHAIN4) ? {1'b0, bus.host_addr[17:2]} :
    (bus.mode == ADDR_DIV2) ? {bus.host_addr[17], bus.host_addr[16:1]} :
    (bus.mode == ADDR_ODD_EVEN) ? bus.host_addr[17:1] :
    bus.host_addr[16:0];

  // results are registered; write enables, read plane and address held between accesses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.write_en <= 4'h0;
      bus.read_plane <= 2'h0;
      bus.mem_addr <= 17'h00000;
      bus.mem_valid <= 1'b0;
    end else begin
      bus.mem_valid <= bus.host_mem_stb;
      if (bus.host_mem_stb) begin
        bus.write_en <= we_nxt;
        bus.read_plane <= rp_nxt;
        bus.mem_addr <= mem_addr_nxt;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_chain4_map;
    bus.host_mem_stb && bus.mode == ADDR_CHAIN4 |=>
      bus.read_plane == $past(bus.host_addr[1:0]) && $countones(bus.write_en) <= 1;
  endproperty
  a_p_chain4_map: assert property (p_chain4_map) else $error("chain4 map wrong");
  property p_plain_map;
    bus.host_mem_stb && bus.mode == ADDR_SEQUENTIAL |=>
      bus.write_en == $past(bus.plane_write_mask) &&
      bus.read_plane == $past(bus.read_plane_select);
  endproperty
  a_p_plain_map: assert property (p_plain_map) else $error("plain map wrong");
  property p_odd_even;
    bus.host_mem_stb && bus.mode == ADDR_ODD_EVEN |=>
      (bus.write_en & ($past(bus.host_addr[0]) ? 4'h5 : 4'ha)) == 4'h0;
  endproperty
  a_p_odd_even: assert property (p_odd_even) else $error("odd/even map wrong");
  property p_div2_addr;
    bus.host_mem_stb && bus.mode == ADDR_DIV2 |=>
      bus.mem_addr == {$past(bus.host_addr[17]), $past(bus.host_addr[16:1])};
  endproperty
  a_p_div2_addr: assert property (p_div2_addr) else $error("div2 address wrong");
  c_chain4: cover property (bus.host_mem_stb && bus.mode == ADDR_CHAIN4);
  c_div2: cover property (bus.host_mem_stb && bus.mode == ADDR_DIV2);

endmodule : plane_mapper
`default_nettype wire

// [tb/host_io_model.sv]
// host cpu model driving the sequencer index and data ports
`timescale 1ns/1ps
`default_nettype none
`include "svga_seq_params.svh"
module host_io_model (
  input wire logic ref_clk,
  output logic [15:0] io_addr,
  output logic io_wr_stb,
  output logic io_rd_stb,
  output logic [7:0] io_wdata,
  output logic ext_unlocked
);
  // idle bus at time zero, extension register locked
  initial begin
    io_addr = 16'h0000;
    io_wr_stb = 1'b0;
    io_rd_stb = 1'b0;
    io_wdata = 8'h00;
    ext_unlocked = 1'b0;
  end

  // one strobed i/o cycle; released lines show inverted values, not stale ones
  task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    #1;
    io_addr = addr;
    io_wdata = data;
    io_wr_stb = wr;
    io_rd_stb = ~wr;
    @(posedge ref_clk);
    #1;
    io_wr_stb = 1'b0;
    io_rd_stb = 1'b0;
    io_addr = ~addr;
    io_wdata = ~data;
  endtask : io_cycle

  // indexed write; software keeps memory mode bit 2 opposite graphics odd/even
  task automatic seq_write(input logic [7:0] idx, input logic [7:0] data);
    io_cycle(1'b1, `SEQ_INDEX_PORT, idx);
    io_cycle(1'b1, `SEQ_DATA_PORT, data);
  endtask : seq_write

  // indexed read; the data shows up on the device outputs
  task automatic seq_read(input logic [7:0] idx);
    io_cycle(1'b1, `SEQ_INDEX_PORT, idx);
    io_cycle(1'b0, `SEQ_DATA_PORT, 8'h00);
  endtask : seq_read

  // software opens the extension register before touching it
  task automatic unlock(input logic en);
    @(posedge ref_clk);
    #1;
    ext_unlocked = en;
  endtask : unlock
endmodule : host_io_model
`default_nettype wire

// [tb/svga_seq_memory_mode_ctrl_bench.sv]
// self-checking bench for the sequencer memory mode and extension block
`timescale 1ns/1ps
`default_nettype none
`include "svga_seq_params.svh"
module svga_seq_memory_mode_ctrl_bench;
  import svga_seq_pkg::*;
  logic ref_clk, rst_n, io_wr_stb, io_rd_stb, ext_unlocked, io_rd_ack_r, io_rd_hit_r;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata_r, clk_mode, start_lo, start_hi, font_byte, font_out;
  logic [3:0] plane_mask, plane_write_en, char_width_r;
  logic [1:0] read_sel, read_plane;
  logic host_mem_stb, mem_access_valid, ext_mem, odd_even, interlace, last_px, dual, hde;
  logic [17:0] host_addr;
  logic [16:0] mem_addr, start_addr;
  logic [7:0] mm_v, ec_v; // register values the bench believes are loaded
  logic [8:0] rd_q[$]; // expected {hit, data} per read
  logic [22:0] map_q[$]; // expected {we, plane, address} per access
  int err_total, compares, seed;

  // device under test
  svga_seq_memory_mode_ctrl i_svga_seq_memory_mode_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata),
    .io_rdata_r(io_rdata_r), .io_rd_ack_r(io_rd_ack_r), .io_rd_hit_r(io_rd_hit_r),
    .ext_unlocked(ext_unlocked), .seq_clocking_mode_reg(clk_mode),
    .plane_write_mask(plane_mask), .read_plane_select(read_sel), .start_addr_lo(start_lo),
    .start_addr_hi(start_hi), .host_mem_stb(host_mem_stb), .host_addr(host_addr),
    .plane_write_en(plane_write_en), .read_plane(read_plane), .memory_address_out(mem_addr),
    .mem_access_valid(mem_access_valid), .font_byte(font_byte), .font_byte_ordered_r(font_out),
    .extended_memory_flag_r(ext_mem), .odd_even_mode_r(odd_even), .char_width_r(char_width_r),
    .serial_start_addr_r(start_addr), .interlace_en_r(interlace),
    .last_pixel_vga_rule_r(last_px), .dual_frame_en_r(dual), .hde_counts_pixels_r(hde));

  // host model on the i/o port
  host_io_model i_host_io_model (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr_stb(io_wr_stb),
    .io_rd_stb(io_rd_stb), .io_wdata(io_wdata), .ext_unlocked(ext_unlocked));

  // 200 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // counts one comparison and reports a miss
  task automatic note(input logic bad, input string what);
    compares++;
    if (bad) begin
      err_total++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask : note

  // per-kind comparisons
  task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
    note(got !== exp, "register read");
  endtask : cmp_rd
  task automatic cmp_map(input logic [22:0] got, input logic [22:0] exp);
    note(got !== exp, "plane mapping");
  endtask : cmp_map
  task automatic cmp_ctl(input logic [16:0] got, input logic [16:0] exp);
    note(got !== exp, "display control");
  endtask : cmp_ctl

  // expected planes and address of one host access
  function automatic logic [22:0] map_exp(input logic [3:0] msk, input logic [1:0] rs,
    input logic [17:0] a);
    if (mm_v[`MM_CHAIN4_BIT]) return {(4'h1 << a[1:0]) & msk, a[1:0], 1'b0, a[17:2]};
    if (ec_v[`EC_DIV2_BIT]) return {(a[0] ? 4'hc : 4'h3) & msk, a[0], rs[0], a[17], a[16:1]};
    if (!mm_v[`MM_SEQ_ADDR_BIT]) return {(a[0] ? 4'ha : 4'h5) & msk, rs[1], a[0], a[17:1]};
    return {msk, rs, a[16:0]};
  endfunction : map_exp

  // queue a read expectation and issue the read
  task automatic rd(input logic [7:0] idx, input logic [8:0] exp);
    rd_q.push_back(exp);
    i_host_io_model.seq_read(idx);
  endtask : rd

  // let derived outputs follow, then check every display control
  task automatic settle_ctl();
    logic [3:0] w;
    logic [7:0] f;
    w = `CHAR_WIDTH_BASE + {1'b0, ec_v[1:0], 1'b0} + {3'b000, ~clk_mode[0]};
    for (int i = 0; i < 8; i++) f[i] = ec_v[`EC_ORDER_BIT] ? font_byte[7 - i] : font_byte[i];
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_ctl(17'(char_width_r), 17'(w));
    cmp_ctl(start_addr, {ec_v[`EC_START16_BIT], start_hi, start_lo});
    cmp_ctl(17'({interlace, last_px}), 17'({ec_v[3], ~clk_mode[0] & ~ec_v[5]}));
    cmp_ctl(17'({dual, hde}), 17'({2{ec_v[`EC_DUAL_BIT]}}));
    cmp_ctl(17'(font_out), 17'(f));
    cmp_ctl(17'({ext_mem, odd_even}), 17'({mm_v[1], ~mm_v[2] & ~mm_v[3]}));
  endtask : settle_ctl

  // watches the outputs and takes the oldest expectation per result
  always @(negedge ref_clk) begin
    if (io_rd_ack_r === 1'b1) begin
      if (rd_q.size() == 0) note(1'b1, "unrequested read answer");
      else cmp_rd({io_rd_hit_r, io_rdata_r}, rd_q.pop_front());
    end
    if (mem_access_valid === 1'b1) begin
      if (map_q.size() == 0) note(1'b1, "unrequested access");
      else cmp_map({plane_write_en, read_plane, mem_addr}, map_q.pop_front());
    end
  end

  // verdict; leftover expectations mean missing answers
  task automatic results();
    if (rd_q.size() != 0 || map_q.size() != 0) err_total++;
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // cuts a hang short
  initial begin
    #50000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    seed = 14;
    rst_n = 1'b0;
    host_mem_stb = 1'b0;
    host_addr = 18'h00000;
    plane_mask = 4'hf;
    read_sel = 2'h0;
    clk_mode = 8'($random(seed));
    start_lo = 8'($random(seed));
    start_hi = 8'($random(seed));
    font_byte = 8'($random(seed));
    mm_v = `MEM_MODE_RST;
    ec_v = `EXT_CTRL0_RST;
    #3;
    cmp_ctl(17'(char_width_r), 17'(`CHAR_WIDTH_BASE));
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // reset values, then an unmapped index
    rd(`IDX_MEM_MODE, {1'b1, `MEM_MODE_RST});
    i_host_io_model.unlock(1'b1);
    rd(`IDX_EXT_CTRL0, {1'b1, `EXT_CTRL0_RST});
    rd(8'h07, 9'h000);
    // index port reads back the last index; a foreign port gets no hit
    rd_q.push_back({1'b1, 8'h07});
    i_host_io_model.io_cycle(1'b0, `SEQ_INDEX_PORT, 8'h00);
    rd_q.push_back(9'h000);
    i_host_io_model.io_cycle(1'b0, 16'h03c6, 8'h00);
    // reserved memory mode bits are dropped
    i_host_io_model.seq_write(`IDX_MEM_MODE, 8'hff);
    mm_v = 8'hff & `MEM_MODE_RW_MASK;
    rd(`IDX_MEM_MODE, {1'b1, mm_v});
    settle_ctl();
    // locked extension register refuses writes and reads zero
    i_host_io_model.unlock(1'b0);
    i_host_io_model.seq_write(`IDX_EXT_CTRL0, 8'hfe);
    rd(`IDX_EXT_CTRL0, 9'h100);
    i_host_io_model.unlock(1'b1);
    rd(`IDX_EXT_CTRL0, {1'b1, ec_v});
    // every width code with both clocking mode settings, other bits random
    for (int k = 0; k < 8; k++) begin
      ec_v = {6'($random(seed)), 2'(k)};
      clk_mode = {7'($random(seed)), k[2]};
      font_byte = 8'($random(seed));
      i_host_io_model.seq_write(`IDX_EXT_CTRL0, ec_v);
      rd(`IDX_EXT_CTRL0, {1'b1, ec_v});
      settle_ctl();
    end
    // each addressing scheme, chain-four first with divide-by-2 also set
    for (int m = 0; m < 4; m++) begin
      mm_v = (m == 0) ? 8'h08 : ((m == 2) ? 8'h00 : 8'h04);
      ec_v = (m < 2) ? 8'h10 : 8'h00;
      i_host_io_model.seq_write(`IDX_MEM_MODE, mm_v);
      i_host_io_model.seq_write(`IDX_EXT_CTRL0, ec_v);
      settle_ctl();
      for (int i = 0; i < 8; i++) begin
        @(posedge ref_clk);
        #1;
        host_addr = 18'($random(seed));
        plane_mask = 4'($random(seed));
        read_sel = 2'($random(seed));
        host_mem_stb = 1'b1;
        map_q.push_back(map_exp(plane_mask, read_sel, host_addr));
      end
      @(posedge ref_clk);
      #1;
      host_mem_stb = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    results();
  end
endmodule : svga_seq_memory_mode_ctrl_bench
`default_nettype wire
